// ### src/psc_pkg.sv
package psc_pkg;
	// Report identifiers; the pin report id is chosen locally
	localparam logic [7:0] RPT_ID_PIN = 8'h65;
	localparam logic [7:0] RPT_ID_LANG = 8'h67;
	localparam logic [7:0] RPT_ID_LOCK = 8'h68;
	// Byte offsets inside the pin report
	localparam logic [3:0] OFS_SERIAL_CFG = 4'h1;
	localparam logic [3:0] OFS_STAT1_CFG = 4'h2;
	localparam logic [3:0] OFS_STAT2_CFG = 4'h3;
	localparam logic [3:0] OFS_LEVEL_LO = 4'h4;
	localparam logic [3:0] OFS_LEVEL_HI = 4'h5;
	localparam logic [3:0] OFS_MODE_LO = 4'h6;
	localparam logic [3:0] OFS_MODE_HI = 4'h7;
	// Byte offsets inside the language and lock reports
	localparam logic [3:0] OFS_LANG_LO = 4'h1;
	localparam logic [3:0] OFS_LANG_HI = 4'h2;
	localparam logic [3:0] OFS_LOCK = 4'h2;
	// Serial data pin byte fields
	localparam int SER_PULLUP_BIT = 7;
	localparam int SER_PULLDN_BIT = 6;
	localparam int SER_WAKE_BIT = 5;
	localparam logic [7:0] SER_CFG_MASK = 8'he3;
	// Status pin byte fields
	localparam int STAT_FXN_LSB = 2;
	localparam logic [7:0] STAT_CFG_MASK = 8'h1f;
	// Driver select codes, shared by all pin bytes
	localparam logic [1:0] DRV_OPEN_DRAIN = 2'h1;
	localparam logic [1:0] DRV_PUSH_PULL = 2'h2;
	// Status function codes
	localparam logic [2:0] FXN_PAIR = 3'h0;
	localparam logic [2:0] FXN_SUSP = 3'h1;
	localparam logic [2:0] FXN_LOWPWR = 3'h2;
	localparam logic [2:0] FXN_BUSRST = 3'h3;
	// Suspend words
	localparam int OVERRIDE_BIT = 15;
	localparam logic [15:0] LEVEL_MASK = 16'h3ccf;
	localparam logic [15:0] MODE_MASK = 16'hbccf;
	localparam int NUM_GPIO = 10;
	// Reset values
	localparam logic [7:0] RST_SERIAL_CFG = 8'h02;
	localparam logic [7:0] RST_STAT1_CFG = 8'h0a;
	localparam logic [7:0] RST_STAT2_CFG = 8'h1a;
	localparam logic [15:0] RST_LEVEL = 16'h0000;
	localparam logic [15:0] RST_MODE = 16'h0000;
	localparam logic [15:0] RST_LANG = 16'h0409;
	// Defaults for the other pins; no module here uses them
	localparam logic [7:0] RST_GPIO_INPUT = 8'h00;
	localparam logic [7:0] RST_GPIO_FUNC = 8'h03;
	localparam logic [7:0] RST_GPIO_PP = 8'h02;
endpackage

// ### src/psc_pin_if.sv
`timescale 1ns/1ps
`default_nettype none
// Normal-mode pin drive handed to the suspend stage
interface psc_pin_if;
	logic [9:0] val;
	logic [9:0] oe;
	logic clk0_sel;
	logic [9:0] xcvr_sel;
	logic xcvr_high;
	modport src (output val, output oe, output clk0_sel, output xcvr_sel, output xcvr_high);
	modport sus (input val, input oe, input clk0_sel, input xcvr_sel, input xcvr_high);
endinterface
`default_nettype wire

// ### src/psc_suspend_hold.sv
`timescale 1ns/1ps
`default_nettype none
module psc_suspend_hold
	import psc_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic usb_suspend,
	input wire logic [15:0] level_word,
	input wire logic [15:0] mode_word,
	psc_pin_if.sus pins,
	output logic [9:0] gpio_o,
	output logic [9:0] gpio_oe
);
	logic [9:0] held_val_q, held_val_d;
	logic [9:0] held_oe_q, held_oe_d;
	logic [9:0] out_q, out_d;
	logic [9:0] oe_q, oe_d;
	logic [9:0] ovr_val, ovr_oe;
	logic override;

	// Word bit that serves a given GPIO
	function automatic int word_bit(input int pin);
		if (pin < 4) begin
			return pin;
		end else if (pin < 6) begin
			return pin + 2;
		end else begin
			return pin + 4;
		end
	endfunction

	assign override = mode_word[OVERRIDE_BIT];

	// Override drive per pin; special functions win over the level word
	for (genvar i = 0; i < NUM_GPIO; i++) begin : g_pin
		logic lvl;
		always_comb begin
			lvl = level_word[word_bit(i)];
			if (i == 0 && pins.clk0_sel) begin
				lvl = 1'b0;
			end
			if (pins.xcvr_sel[i]) begin
				lvl = ~pins.xcvr_high;
			end
			if (mode_word[word_bit(i)]) begin
				ovr_val[i] = lvl;
				ovr_oe[i] = 1'b1;
			end else begin
				ovr_val[i] = 1'b0;
				ovr_oe[i] = ~lvl;
			end
		end
	end

	// Snapshot tracks live drive until suspend, then freezes
	always_comb begin
		held_val_d = usb_suspend ? held_val_q : pins.val;
		held_oe_d = usb_suspend ? held_oe_q : pins.oe;
		if (!usb_suspend) begin
			out_d = pins.val;
			oe_d = pins.oe;
		end else if (override) begin
			out_d = ovr_val;
			oe_d = ovr_oe;
		end else begin
			out_d = held_val_q;
			oe_d = held_oe_q;
		end
		if (!ce) begin
			held_val_d = held_val_q;
			held_oe_d = held_oe_q;
			out_d = out_q;
			oe_d = oe_q;
		end
	end

	// Pins come from flops so nothing glitches at suspend entry
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			held_val_q <= 10'h000;
			held_oe_q <= 10'h000;
			out_q <= 10'h000;
			oe_q <= 10'h000;
		end else begin
			held_val_q <= held_val_d;
			held_oe_q <= held_oe_d;
			out_q <= out_d;
			oe_q <= oe_d;
		end
	end

	assign gpio_o = out_q;
	assign gpio_oe = oe_q;
endmodule
`default_nettype wire

// ### src/psc_pin_suspend_cfg.sv
`timescale 1ns/1ps
`default_nettype none
module psc_pin_suspend_cfg
	import psc_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic rpt_wr,
	input wire logic rpt_rd,
	input wire logic [7:0] rpt_id,
	input wire logic [3:0] rpt_ofs,
	input wire logic [7:0] rpt_wdata,
	output logic [7:0] rpt_rdata,
	output logic rpt_rvalid,
	input wire logic usb_suspend,
	input wire logic usb_bus_reset,
	input wire logic usb_configured,
	input wire logic remote_wake_allowed,
	input wire logic rx_pin,
	output logic rx_pullup_en,
	output logic rx_pulldown_en,
	output logic host_wake_req,
	input wire logic tx_data,
	output logic tx_o,
	output logic tx_oe,
	output logic first_status_pin_o,
	output logic first_status_pin_oe,
	output logic second_status_pin_o,
	output logic second_status_pin_oe,
	input wire logic [9:0] gpio_val,
	input wire logic [9:0] gpio_drv_oe,
	input wire logic pin0_clock_out,
	input wire logic pin3_transceiver_enable,
	input wire logic pin1_transceiver_enable,
	input wire logic transceiver_active_high,
	output logic [9:0] gpio_o,
	output logic [9:0] gpio_oe,
	input wire logic lock_stored,
	output logic lock_program_req,
	output logic global_lock_active,
	output logic [15:0] language_code
);
	logic [7:0] ser_cfg_q, ser_cfg_d;
	logic [7:0] stat1_cfg_q, stat1_cfg_d;
	logic [7:0] stat2_cfg_q, stat2_cfg_d;
	logic [15:0] level_q, level_d;
	logic [15:0] mode_q, mode_d;
	logic [15:0] lang_q, lang_d;
	logic [7:0] rdata_q, rdata_d;
	logic rvalid_q, rvalid_d;
	logic lock_req_q, lock_req_d;
	logic lock_act_q, lock_act_d;
	logic lock_done_q, lock_done_d;
	logic [2:0] rx_sync_q, rx_sync_d;
	logic rx_stable_q, rx_stable_d;
	logic wake_q, wake_d;
	logic tx_o_q, tx_o_d, tx_oe_q, tx_oe_d;
	logic [1:0] st_o_q, st_o_d, st_oe_q, st_oe_d;
	logic [7:0] rd_byte;
	logic rx_change;

	psc_pin_if pin_bus ();

	assign pin_bus.val = gpio_val;
	assign pin_bus.oe = gpio_drv_oe;
	assign pin_bus.clk0_sel = pin0_clock_out;
	assign pin_bus.xcvr_sel = {6'h00, pin3_transceiver_enable, 1'b0, pin1_transceiver_enable, 1'b0};
	assign pin_bus.xcvr_high = transceiver_active_high;

	psc_suspend_hold u_hold (
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.usb_suspend(usb_suspend),
		.level_word(level_q),
		.mode_word(mode_q),
		.pins(pin_bus.sus),
		.gpio_o(gpio_o),
		.gpio_oe(gpio_oe)
	);

	// Level of one status pin from its function code
	function automatic logic status_level(input logic [7:0] cfg, input logic second,
		input logic susp, input logic brst, input logic cfgd);
		logic [2:0] status_function_select;
		logic ev;
		status_function_select = cfg[STAT_FXN_LSB +: 3];
		case (status_function_select[1:0])
			FXN_PAIR[1:0]: ev = (susp | brst) ^ second;
			FXN_SUSP[1:0]: ev = susp;
			FXN_LOWPWR[1:0]: ev = susp | ~cfgd;
			FXN_BUSRST[1:0]: ev = brst;
			default: ev = 1'b0;
		endcase
		// Upper code bit inverts, except for the paired mode
		if (status_function_select[2] && status_function_select[1:0] != FXN_PAIR[1:0]) begin
			ev = ~ev;
		end
		return ev;
	endfunction

	// Driver stage: output value and enable for a level and a driver code
	function automatic logic [1:0] drive(input logic [1:0] code, input logic lvl);
		case (code)
			DRV_OPEN_DRAIN: drive = {1'b0, ~lvl};
			DRV_PUSH_PULL: drive = {lvl, 1'b1};
			default: drive = 2'b00; // Reserved codes leave the pin floating
		endcase
	endfunction

	// Read mux over the three reports
	always_comb begin
		rd_byte = 8'h00;
		case (rpt_id)
			RPT_ID_PIN: begin
				case (rpt_ofs)
					OFS_SERIAL_CFG: rd_byte = ser_cfg_q;
					OFS_STAT1_CFG: rd_byte = stat1_cfg_q;
					OFS_STAT2_CFG: rd_byte = stat2_cfg_q;
					OFS_LEVEL_LO: rd_byte = level_q[7:0];
					OFS_LEVEL_HI: rd_byte = level_q[15:8];
					OFS_MODE_LO: rd_byte = mode_q[7:0];
					OFS_MODE_HI: rd_byte = mode_q[15:8];
					default: rd_byte = 8'h00;
				endcase
			end
			RPT_ID_LANG: begin
				case (rpt_ofs)
					OFS_LANG_LO: rd_byte = lang_q[7:0];
					OFS_LANG_HI: rd_byte = lang_q[15:8];
					default: rd_byte = 8'h00;
				endcase
			end
			RPT_ID_LOCK: rd_byte = (rpt_ofs == OFS_LOCK) ? {7'h00, lock_act_q} : 8'h00;
			default: rd_byte = 8'h00;
		endcase
	end

	// Register writes; masks drop reserved bits
	always_comb begin
		ser_cfg_d = ser_cfg_q;
		stat1_cfg_d = stat1_cfg_q;
		stat2_cfg_d = stat2_cfg_q;
		level_d = level_q;
		mode_d = mode_q;
		lang_d = lang_q;
		lock_req_d = 1'b0;
		rdata_d = rdata_q;
		rvalid_d = 1'b0;
		if (ce && rpt_wr) begin
			case (rpt_id)
				RPT_ID_PIN: begin
					case (rpt_ofs)
						OFS_SERIAL_CFG: ser_cfg_d = rpt_wdata & SER_CFG_MASK;
						OFS_STAT1_CFG: stat1_cfg_d = rpt_wdata & STAT_CFG_MASK;
						OFS_STAT2_CFG: stat2_cfg_d = rpt_wdata & STAT_CFG_MASK;
						OFS_LEVEL_LO: level_d[7:0] = rpt_wdata & LEVEL_MASK[7:0];
						OFS_LEVEL_HI: level_d[15:8] = rpt_wdata & LEVEL_MASK[15:8];
						OFS_MODE_LO: mode_d[7:0] = rpt_wdata & MODE_MASK[7:0];
						OFS_MODE_HI: mode_d[15:8] = rpt_wdata & MODE_MASK[15:8];
						default: ;
					endcase
				end
				RPT_ID_LANG: begin
					if (rpt_ofs == OFS_LANG_LO) begin
						lang_d[7:0] = rpt_wdata;
					end
					if (rpt_ofs == OFS_LANG_HI) begin
						lang_d[15:8] = rpt_wdata;
					end
				end
				RPT_ID_LOCK: lock_req_d = (rpt_ofs == OFS_LOCK) & rpt_wdata[0];
				default: ;
			endcase
		end
		if (ce && rpt_rd) begin
			rdata_d = rd_byte;
			rvalid_d = 1'b1;
		end
	end

	// Lock state is sampled once after reset release, never on the write
	always_comb begin
		lock_done_d = lock_done_q | ce;
		lock_act_d = lock_act_q;
		if (ce && !lock_done_q) begin
			lock_act_d = lock_stored;
		end
	end

	// Receive pin sync; a change counts once stages two and three agree
	always_comb begin
		rx_sync_d = ce ? {rx_sync_q[1:0], rx_pin} : rx_sync_q;
		rx_change = (rx_sync_q[1] == rx_sync_q[2]) && (rx_sync_q[2] != rx_stable_q);
		rx_stable_d = (ce && rx_change) ? rx_sync_q[2] : rx_stable_q;
		wake_d = ce ? (rx_change & usb_suspend & ser_cfg_q[SER_WAKE_BIT]
			& remote_wake_allowed) : wake_q;
	end

	// Transmit and status pin drivers, registered
	always_comb begin
		{tx_o_d, tx_oe_d} = drive(ser_cfg_q[1:0], tx_data);
		{st_o_d[0], st_oe_d[0]} = drive(stat1_cfg_q[1:0],
			status_level(stat1_cfg_q, 1'b0, usb_suspend, usb_bus_reset, usb_configured));
		{st_o_d[1], st_oe_d[1]} = drive(stat2_cfg_q[1:0],
			status_level(stat2_cfg_q, 1'b1, usb_suspend, usb_bus_reset, usb_configured));
		if (!ce) begin
			tx_o_d = tx_o_q;
			tx_oe_d = tx_oe_q;
			st_o_d = st_o_q;
			st_oe_d = st_oe_q;
		end
	end

	// All state of this module; defaults match the reset pin table
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ser_cfg_q <= RST_SERIAL_CFG;
			stat1_cfg_q <= RST_STAT1_CFG;
			stat2_cfg_q <= RST_STAT2_CFG;
			level_q <= RST_LEVEL;
			mode_q <= RST_MODE;
			lang_q <= RST_LANG;
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
			lock_req_q <= 1'b0;
			lock_act_q <= 1'b0;
			lock_done_q <= 1'b0;
			rx_sync_q <= 3'h7;
			rx_stable_q <= 1'b1;
			wake_q <= 1'b0;
			tx_o_q <= 1'b0;
			tx_oe_q <= 1'b0;
			st_o_q <= 2'h0;
			st_oe_q <= 2'h0;
		end else begin
			ser_cfg_q <= ser_cfg_d;
			stat1_cfg_q <= stat1_cfg_d;
			stat2_cfg_q <= stat2_cfg_d;
			level_q <= level_d;
			mode_q <= mode_d;
			lang_q <= lang_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
			lock_req_q <= lock_req_d;
			lock_act_q <= lock_act_d;
			lock_done_q <= lock_done_d;
			rx_sync_q <= rx_sync_d;
			rx_stable_q <= rx_stable_d;
			wake_q <= wake_d;
			tx_o_q <= tx_o_d;
			tx_oe_q <= tx_oe_d;
			st_o_q <= st_o_d;
			st_oe_q <= st_oe_d;
		end
	end

	assign rx_pullup_en = ser_cfg_q[SER_PULLUP_BIT];
	assign rx_pulldown_en = ser_cfg_q[SER_PULLDN_BIT] & ~ser_cfg_q[SER_PULLUP_BIT];
	assign host_wake_req = wake_q;
	assign tx_o = tx_o_q;
	assign tx_oe = tx_oe_q;
	assign first_status_pin_o = st_o_q[0];
	assign first_status_pin_oe = st_oe_q[0];
	assign second_status_pin_o = st_o_q[1];
	assign second_status_pin_oe = st_oe_q[1];
	assign rpt_rdata = rdata_q;
	assign rpt_rvalid = rvalid_q;
	assign lock_program_req = lock_req_q;
	assign global_lock_active = lock_act_q;
	assign language_code = lang_q;
endmodule
`default_nettype wire

// ### testbench/psc_pin_suspend_cfg_sva.sv
`timescale 1ns/1ps
`default_nettype none
module psc_cfg_chk
	import psc_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic rpt_wr,
	input wire logic rpt_rd,
	input wire logic [7:0] rpt_id,
	input wire logic [3:0] rpt_ofs,
	input wire logic [7:0] rpt_wdata,
	input wire logic [7:0] rpt_rdata,
	input wire logic rpt_rvalid,
	input wire logic usb_suspend,
	input wire logic usb_bus_reset,
	input wire logic usb_configured,
	input wire logic remote_wake_allowed,
	input wire logic rx_pullup_en,
	input wire logic rx_pulldown_en,
	input wire logic host_wake_req,
	input wire logic tx_data,
	input wire logic tx_o,
	input wire logic tx_oe,
	input wire logic first_status_pin_o,
	input wire logic second_status_pin_o,
	input wire logic lock_program_req,
	input wire logic global_lock_active,
	input wire logic [15:0] language_code
);
	logic [7:0] ser_q, st1_q, st2_q;
	logic [1:0] seen_q;
	logic pw, e1, e2;
	logic [3:0] t;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// Expected status levels; the pair code inverts on the second pin
	assign pw = rpt_wr && ce && rpt_id == RPT_ID_PIN;
	assign t = {usb_bus_reset, usb_suspend | !usb_configured, usb_suspend, usb_suspend | usb_bus_reset};
	assign e1 = t[st1_q[3:2]] ^ (st1_q[3:2] != 2'h0 && st1_q[4]);
	assign e2 = t[st2_q[3:2]] ^ (st2_q[3:2] != 2'h0 ? st2_q[4] : 1'b1);
	// Shadow of the pin bytes, seen only through the write port
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ser_q <= RST_SERIAL_CFG;
			st1_q <= RST_STAT1_CFG;
			st2_q <= RST_STAT2_CFG;
			seen_q <= 2'h0;
		end else begin
			seen_q <= {seen_q[0], 1'b1};
			if (pw && rpt_ofs == OFS_SERIAL_CFG) ser_q <= rpt_wdata & SER_CFG_MASK;
			if (pw && rpt_ofs == OFS_STAT1_CFG) st1_q <= rpt_wdata & STAT_CFG_MASK;
			if (pw && rpt_ofs == OFS_STAT2_CFG) st2_q <= rpt_wdata & STAT_CFG_MASK;
		end
	end
	a_pullup_bit: assert property (rx_pullup_en == ser_q[SER_PULLUP_BIT])
		else $error("pull-up differs from its bit");
	a_pulldown_excl: assert property (rx_pulldown_en == (ser_q[6] && !ser_q[7]))
		else $error("pull-down not exclusive");
	a_wake_gated: assert property (host_wake_req |-> $past(usb_suspend) && $past(remote_wake_allowed) && $past(ser_q[SER_WAKE_BIT]))
		else $error("wake without its conditions");
	a_tx_push_pull: assert property (ser_q[1:0] == DRV_PUSH_PULL |=> tx_oe && tx_o == $past(tx_data))
		else $error("tx push-pull wrong");
	a_tx_open_drain: assert property (ser_q[1:0] == DRV_OPEN_DRAIN |=> !tx_o && tx_oe == !$past(tx_data))
		else $error("tx open-drain wrong");
	a_stat1_level: assert property (st1_q[1:0] == DRV_PUSH_PULL |=> first_status_pin_o == $past(e1))
		else $error("first status level wrong");
	a_stat2_level: assert property (st2_q[1:0] == DRV_PUSH_PULL |=> second_status_pin_o == $past(e2))
		else $error("second status level wrong");
	a_lang_high: assert property (ce && rpt_wr && rpt_id == RPT_ID_LANG && rpt_ofs == OFS_LANG_HI |=> language_code[15:8] == $past(rpt_wdata))
		else $error("language high byte wrong");
	a_lock_request: assert property (ce && rpt_wr && rpt_id == RPT_ID_LOCK && rpt_ofs == OFS_LOCK && rpt_wdata[0] |=> lock_program_req)
		else $error("lock write not requested");
	a_lock_deferred: assert property (seen_q[1] |-> $stable(global_lock_active))
		else $error("lock changed outside reset");
	a_serial_rdback: assert property (ce && rpt_rd && rpt_id == RPT_ID_PIN && rpt_ofs == OFS_SERIAL_CFG |=> rpt_rvalid && rpt_rdata == $past(ser_q))
		else $error("serial byte read back wrong");
endmodule
bind psc_pin_suspend_cfg psc_cfg_chk u_chk (.clk, .arst_n, .ce, .rpt_wr, .rpt_rd, .rpt_id, .rpt_ofs,
	.rpt_wdata, .rpt_rdata, .rpt_rvalid, .usb_suspend, .usb_bus_reset, .usb_configured,
	.remote_wake_allowed, .rx_pullup_en, .rx_pulldown_en, .host_wake_req, .tx_data, .tx_o, .tx_oe,
	.first_status_pin_o, .second_status_pin_o, .lock_program_req, .global_lock_active,
	.language_code);
`default_nettype wire

// ### testbench/psc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module psc_host_model
	import psc_pkg::*;
(
	input wire logic clk,
	output logic rpt_wr,
	output logic rpt_rd,
	output logic [7:0] rpt_id,
	output logic [3:0] rpt_ofs,
	output logic [7:0] rpt_wdata,
	input wire logic [7:0] rpt_rdata,
	input wire logic rpt_rvalid
);
	// Idle report port; all strobes low and all fields zero
	initial begin
		{rpt_wr, rpt_rd} = 2'h0;
		{rpt_id, rpt_ofs, rpt_wdata} = '0;
	end
	// One byte write; stale data is inverted so it cannot pass for a hold
	task automatic wr(input logic [7:0] i, input logic [3:0] o, input logic [7:0] d);
		@(negedge clk);
		{rpt_id, rpt_ofs, rpt_wdata} = {i, o, d};
		rpt_wr = 1'b1;
		@(negedge clk);
		rpt_wr = 1'b0;
		rpt_wdata = ~d;
	endtask
	// One byte read; ok stays low if no answer within four edges
	task automatic rd(input logic [7:0] i, input logic [3:0] o, output logic [7:0] d, output logic ok);
		@(negedge clk);
		{rpt_id, rpt_ofs} = {i, o};
		rpt_rd = 1'b1;
		ok = 1'b0;
		d = 8'h00;
		// Valid stands for one cycle only, so look at each falling edge
		for (int k = 0; k < 4 && !ok; k++) begin
			@(negedge clk);
			rpt_rd = 1'b0;
			ok = (rpt_rvalid === 1'b1);
			d = rpt_rdata;
		end
	endtask
endmodule
`default_nettype wire

// ### testbench/psc_pin_suspend_cfg_tb.sv
`timescale 1ns/1ps
`default_nettype none
module psc_pin_suspend_cfg_tb
	import psc_pkg::*;
;
	logic clk, arst_n, ce, susp, brst, cfgd, rwk, rx_pin, tx_data, clk0, x3, lock_st, ok, e;
	logic x1, xh;
	logic wr, rd, rvalid, pu, pd, wake, tx_o, tx_oe, s1o, s1e, s2o, s2e, lreq, lact;
	logic [9:0] gval, goe, gpio_o, gpio_oe, gv, go;
	logic [7:0] id, wd, rdata, d;
	logic [3:0] ofs;
	logic [15:0] lang, lw, mw;
	logic [7:0] msk [8];
	logic [7:0] m [8];
	int error_cnt, checked, seed, b;
	psc_host_model host (.clk(clk), .rpt_wr(wr), .rpt_rd(rd), .rpt_id(id), .rpt_ofs(ofs),
		.rpt_wdata(wd), .rpt_rdata(rdata), .rpt_rvalid(rvalid));
	psc_pin_suspend_cfg dut (.clk(clk), .arst_n(arst_n), .ce(ce), .rpt_wr(wr), .rpt_rd(rd),
		.rpt_id(id), .rpt_ofs(ofs), .rpt_wdata(wd), .rpt_rdata(rdata), .rpt_rvalid(rvalid),
		.usb_suspend(susp), .usb_bus_reset(brst), .usb_configured(cfgd),
		.remote_wake_allowed(rwk), .rx_pin(rx_pin), .rx_pullup_en(pu), .rx_pulldown_en(pd),
		.host_wake_req(wake), .tx_data(tx_data), .tx_o(tx_o), .tx_oe(tx_oe),
		.first_status_pin_o(s1o), .first_status_pin_oe(s1e), .second_status_pin_o(s2o),
		.second_status_pin_oe(s2e), .gpio_val(gval), .gpio_drv_oe(goe), .pin0_clock_out(clk0),
		.pin3_transceiver_enable(x3), .pin1_transceiver_enable(x1),
		.transceiver_active_high(xh), .gpio_o(gpio_o), .gpio_oe(gpio_oe),
		.lock_stored(lock_st), .lock_program_req(lreq), .global_lock_active(lact),
		.language_code(lang));
	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Status level model: pair code inverts on the second pin
	function automatic logic lv(input logic [2:0] f, input logic [2:0] c, input logic sec);
		logic [3:0] t;
		t = {c[1], c[2] | !c[0], c[2], c[2] | c[1]};
		lv = t[f[1:0]] ^ (f[1:0] == 2'h0 ? sec : f[2]);
	endfunction
	task automatic stop_test();
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [3:0] o, input logic [7:0] x);
		host.rd(RPT_ID_PIN, o, d, ok);
		chk(ok, 1'b1);
		if (!ok) stop_test();
		chk(d, x);
	endtask
	task automatic do_reset();
		arst_n = 1'b0;
		repeat (10) @(negedge clk);
		arst_n = 1'b1;
	endtask
	// Main sequence
	initial begin
		// Receive pin idles high, so reset sees no false edge
		{ce, cfgd, rx_pin} = 3'h7;
		{arst_n, susp, brst, rwk, tx_data, clk0, x3, x1, xh, lock_st} = '0;
		{gval, goe} = '0;
		{error_cnt, checked} = 0;
		seed = 64712;
		msk = '{8'h00, SER_CFG_MASK, STAT_CFG_MASK, STAT_CFG_MASK, LEVEL_MASK[7:0],
			LEVEL_MASK[15:8], MODE_MASK[7:0], MODE_MASK[15:8]};
		m = '{8'h00, RST_SERIAL_CFG, RST_STAT1_CFG, RST_STAT2_CFG, RST_LEVEL[7:0],
			RST_LEVEL[15:8], RST_MODE[7:0], RST_MODE[15:8]};
		do_reset();
		for (int i = 1; i < 8; i++) rdchk(i[3:0], m[i]);
		chk(lang, RST_LANG);
		// Random bytes, reserved bits masked; driver codes kept legal
		for (int i = 1; i < 8; i++) begin
			d = 8'($random(seed));
			if (i < 4) d[1:0] = d[0] ? DRV_OPEN_DRAIN : DRV_PUSH_PULL;
			host.wr(RPT_ID_PIN, i[3:0], d);
			m[i] = d & msk[i];
			rdchk(i[3:0], m[i]);
		end
		host.rd(8'h66, 4'h1, d, ok);
		chk(ok, 1'b1);
		chk(d, 8'h00);
		// Pulls and transmit driver
		for (int k = 0; k < 4; k++) begin
			d = k[1] ? (k[0] ? 8'hc1 : 8'h01) : (k[0] ? 8'h42 : 8'h82);
			host.wr(RPT_ID_PIN, OFS_SERIAL_CFG, d);
			tx_data = 1'($random(seed));
			repeat (2) @(negedge clk);
			chk(pu, d[7]);
			chk(pd, d[6] & ~d[7]);
			chk({tx_o, tx_oe}, d[1] ? {tx_data, 1'b1} : {1'b0, ~tx_data});
		end
		// Every status code, both drivers, all USB states
		for (int f = 0; f < 16; f++) begin
			d = {3'h0, f[2:0], f[3] ? DRV_OPEN_DRAIN : DRV_PUSH_PULL};
			host.wr(RPT_ID_PIN, OFS_STAT1_CFG, d);
			host.wr(RPT_ID_PIN, OFS_STAT2_CFG, d);
			for (int c = 0; c < 8; c++) begin
				{susp, brst, cfgd} = c[2:0];
				repeat (2) @(negedge clk);
				e = lv(f[2:0], c[2:0], 1'b0);
				chk({s1o, s1e}, f[3] ? {1'b0, ~e} : {e, 1'b1});
				e = lv(f[2:0], c[2:0], 1'b1);
				chk({s2o, s2e}, f[3] ? {1'b0, ~e} : {e, 1'b1});
			end
		end
		// Override clear: pins freeze at the last drive before suspend
		{susp, brst} = 2'h0;
		host.wr(RPT_ID_PIN, OFS_MODE_HI, 8'h00);
		gv = 10'($random(seed));
		go = 10'($random(seed));
		{gval, goe} = {gv, go};
		repeat (2) @(negedge clk);
		susp = 1'b1;
		@(negedge clk);
		{gval, goe} = {~gv, ~go};
		repeat (2) @(negedge clk);
		chk(gpio_o, gv);
		chk(gpio_oe, go);
		// Override set, with clock output and transceiver enable present
		susp = 1'b0;
		lw = 16'($random(seed));
		mw = 16'($random(seed)) | 16'h8000;
		host.wr(RPT_ID_PIN, OFS_LEVEL_LO, lw[7:0]);
		host.wr(RPT_ID_PIN, OFS_LEVEL_HI, lw[15:8]);
		host.wr(RPT_ID_PIN, OFS_MODE_LO, mw[7:0]);
		host.wr(RPT_ID_PIN, OFS_MODE_HI, mw[15:8]);
		// Both transceiver pins active low, so deasserted means high
		{clk0, x3, x1, xh} = 4'he;
		susp = 1'b1;
		repeat (3) @(negedge clk);
		for (int i = 0; i < 10; i++) begin
			b = i < 4 ? i : (i < 6 ? i + 2 : i + 4);
			e = (i == 0) ? 1'b0 : ((i == 1 || i == 3) ? ~xh : lw[b]);
			chk({gpio_o[i], gpio_oe[i]}, mw[b] ? {e, 1'b1} : {1'b0, ~e});
		end
		// Receive activity wakes the host while suspended
		host.wr(RPT_ID_PIN, OFS_SERIAL_CFG, 8'h22);
		rwk = 1'b1;
		rx_pin = ~rx_pin;
		ok = 1'b0;
		for (int i = 0; i < 8 && !ok; i++) begin
			@(negedge clk);
			ok = (wake === 1'b1);
		end
		chk(ok, 1'b1);
		if (!ok) stop_test();
		// Language code, then a lock that waits for the next reset
		host.wr(RPT_ID_LANG, OFS_LANG_LO, 8'h11);
		host.wr(RPT_ID_LANG, OFS_LANG_HI, 8'h22);
		@(negedge clk);
		chk(lang, 16'h2211);
		// Clock enable low: a write must leave the code untouched
		ce = 1'b0;
		host.wr(RPT_ID_LANG, OFS_LANG_LO, 8'h55);
		chk(lang, 16'h2211);
		ce = 1'b1;
		host.wr(RPT_ID_LOCK, OFS_LOCK, 8'h01);
		chk(lreq, 1'b1);
		lock_st = 1'b1;
		repeat (3) @(negedge clk);
		chk(lact, 1'b0);
		do_reset();
		@(negedge clk);
		chk(lact, 1'b1);
		stop_test();
	end
endmodule
`default_nettype wire
